//--- logic/mdu_byte_regs.v
// six shared operand/result byte registers with registered read data
// assumes one write or read per clock from the owning unit
`timescale 1ns/1ps
module mdu_byte_regs (
  input wire core_clk,
  input wire resetn,
  input wire wr_en,
  input wire [2:0] wr_idx,
  input wire [7:0] wr_data,
  input wire load_en,
  input wire [47:0] load_data,
  input wire [2:0] rd_idx,
  output reg [7:0] rd_data,
  output wire [47:0] all_data
);
  reg [7:0] mem [0:5];
  integer i;
  assign all_data = {mem[5], mem[4], mem[3], mem[2], mem[1], mem[0]};
  always @(posedge core_clk) begin
    if (load_en) begin
      for (i = 0; i < 6; i = i + 1) begin
        mem[i] <= load_data[i*8 +: 8];
      end
    end else if (wr_en && wr_idx < 3'h6) begin
      mem[wr_idx] <= wr_data;
    end
  end
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 8'h00;
    end else if (rd_idx < 3'h6) begin
      rd_data <= mem[rd_idx];
    end else begin
      rd_data <= 8'h00;
    end
  end
endmodule

//--- logic/mdu_defines.vh
// constants for the multiply/divide unit: register indices, status bits, cycle counts
// assumes inclusion by the unit's top design file (mdu_byte_regs does not include it) and its port checker
`ifndef MDU_DEFINES_VH
`define MDU_DEFINES_VH
// ---------------------------------------------------------------
// register indices on the byte port
// ---------------------------------------------------------------
`define MDU_ADDR_W 3
`define MDU_REG0 3'h0
`define MDU_REG1 3'h1
`define MDU_REG2 3'h2
`define MDU_REG3 3'h3
`define MDU_REG4 3'h4
`define MDU_REG5 3'h5
`define MDU_STATUS 3'h6
// ---------------------------------------------------------------
// status bits and reset values
// ---------------------------------------------------------------
`define MDU_ERR_BIT 7
`define MDU_OV_BIT 6
`define MDU_FLAG_RST 1'h0
// ---------------------------------------------------------------
// calculation times in system clock periods
// ---------------------------------------------------------------
`define MDU_CYC_LDIV 5'h11
`define MDU_CYC_SDIV 5'h09
`define MDU_CYC_MUL 5'h0B
`endif

//--- logic/multiply_divide_unit.v
// byte-wide multiply/divide unit: write-order decode, timed compute, status flags
// assumes a single-cycle byte port on core_clk; read data appears one cycle after rd_en
`timescale 1ns/1ps
`include "mdu_defines.vh"
module multiply_divide_unit (
  input wire core_clk,
  input wire resetn,
  input wire wr_en,
  input wire rd_en,
  input wire [`MDU_ADDR_W-1:0] addr,
  input wire [7:0] wr_data,
  output reg [7:0] rd_data,
  output reg busy,
  output reg access_error_flag,
  output reg overflow_flag
);
  // ---------------------------------------------------------------
  // order tracker states
  // ---------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_W0 = 3'h1;
  localparam [2:0] S_W01 = 3'h2;
  localparam [2:0] S_W012 = 3'h3;
  localparam [2:0] S_W0123 = 3'h4;
  localparam [2:0] S_W01234 = 3'h5;
  localparam [2:0] S_W014 = 3'h6;
  localparam [2:0] S_W04 = 3'h7;
  localparam [2:0] S_W041 = 3'h0;
  localparam [1:0] OP_LDIV = 2'h0;
  localparam [1:0] OP_SDIV = 2'h1;
  localparam [1:0] OP_MUL = 2'h2;

  reg [2:0] seq;
  reg seq_041;
  reg [1:0] op;
  reg [4:0] count;
  reg load_en;
  reg [47:0] load_data;
  reg [1:0] next_op;
  reg launch;
  reg [2:0] next_seq;
  reg next_041;
  wire [47:0] all_data;
  wire reg_hit;
  wire stat_hit;
  reg [31:0] product;
  reg [31:0] short_q;

  assign reg_hit = (addr < `MDU_STATUS);
  assign stat_hit = (addr == `MDU_STATUS);

  mdu_byte_regs u_regs (
    .core_clk(core_clk),
    .resetn(resetn),
    .wr_en(wr_en && !busy),
    .wr_idx(addr),
    .wr_data(wr_data),
    .load_en(load_en),
    .load_data(load_data),
    .rd_idx(addr),
    // bytes are read from all_data here to keep a one-cycle read latency
    .rd_data(),
    .all_data(all_data)
  );

  // ---------------------------------------------------------------
  // arithmetic helpers
  // ---------------------------------------------------------------
  function [31:0] div_q;
    input [31:0] dvd;
    input [15:0] dvs;
    begin
      div_q = (dvs == 16'h0000) ? 32'hFFFFFFFF : dvd / {16'h0000, dvs};
    end
  endfunction

  function [15:0] div_r;
    input [31:0] dvd;
    input [15:0] dvs;
    reg [31:0] r;
    begin
      r = (dvs == 16'h0000) ? dvd : dvd % {16'h0000, dvs};
      div_r = r[15:0];
    end
  endfunction

  function [4:0] op_cycles;
    input [1:0] o;
    begin
      case (o)
        OP_LDIV: op_cycles = `MDU_CYC_LDIV;
        OP_SDIV: op_cycles = `MDU_CYC_SDIV;
        default: op_cycles = `MDU_CYC_MUL;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // write order decode
  // ---------------------------------------------------------------
  // seq_041 extends the 3-bit state, since S_W041 shares code 0 with idle
  always @* begin
    next_seq = seq;
    next_041 = seq_041;
    launch = 1'b0;
    next_op = op;
    if (wr_en && reg_hit && !busy) begin
      next_041 = 1'b0;
      if (addr == `MDU_REG0) begin
        next_seq = S_W0;
      end else begin
        next_seq = S_IDLE;
        case (addr)
          `MDU_REG1: begin
            if (seq == S_W0 && !seq_041) next_seq = S_W01;
            else if (seq == S_W04 && !seq_041) begin
              next_seq = S_W041;
              next_041 = 1'b1;
            end
          end
          `MDU_REG2: if (seq == S_W01 && !seq_041) next_seq = S_W012;
          `MDU_REG3: if (seq == S_W012 && !seq_041) next_seq = S_W0123;
          `MDU_REG4: begin
            if (seq == S_W0123 && !seq_041) next_seq = S_W01234;
            else if (seq == S_W01 && !seq_041) next_seq = S_W014;
            else if (seq == S_W0 && !seq_041) next_seq = S_W04;
          end
          `MDU_REG5: begin
            if (seq == S_W01234 && !seq_041) begin
              launch = 1'b1;
              next_op = OP_LDIV;
            end else if (seq == S_W014 && !seq_041) begin
              launch = 1'b1;
              next_op = OP_SDIV;
            end else if (seq_041) begin
              launch = 1'b1;
              next_op = OP_MUL;
            end
          end
          default: next_seq = S_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // result packing
  // ---------------------------------------------------------------
  always @* begin
    product = all_data[15:0] * all_data[47:32];
    short_q = div_q({16'h0000, all_data[15:0]}, all_data[47:32]);
    load_data = all_data;
    case (op)
      OP_LDIV: load_data = {div_r(all_data[31:0], all_data[47:32]),
        div_q(all_data[31:0], all_data[47:32])};
      OP_SDIV: load_data = {div_r({16'h0000, all_data[15:0]}, all_data[47:32]), all_data[31:16],
        short_q[15:0]};
      default: load_data = {all_data[47:32], product};
    endcase
  end

  // ---------------------------------------------------------------
  // sequencing, timing and flags
  // ---------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      seq <= S_IDLE;
      seq_041 <= 1'b0;
      op <= OP_LDIV;
      count <= 5'h00;
      busy <= 1'b0;
      load_en <= 1'b0;
      access_error_flag <= `MDU_FLAG_RST;
      overflow_flag <= `MDU_FLAG_RST;
    end else begin
      seq <= next_seq;
      seq_041 <= next_041;
      op <= next_op;
      load_en <= 1'b0;
      if (launch) begin
        busy <= 1'b1;
        count <= op_cycles(next_op) - 5'h01;
      end else if (busy) begin
        if (count == 5'h01) begin
          load_en <= 1'b1;
        end
        if (count == 5'h00) begin
          busy <= 1'b0;
          // operands still stand in the array at this edge, so product is live
          if (op == OP_MUL) overflow_flag <= (product[31:16] != 16'h0000);
          else overflow_flag <= (all_data[47:32] == 16'h0000);
        end else begin
          count <= count - 5'h01;
        end
      end
      // set wins over a clear in the same cycle
      if (busy && reg_hit && (wr_en || rd_en)) begin
        access_error_flag <= 1'b1;
      end else if (!busy && rd_en && stat_hit) begin
        access_error_flag <= 1'b0;
      end
    end
  end

  // load_en rises one cycle before busy falls and the result regs load on the edge where busy falls, so reads see results at once
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 8'h00;
    end else if (rd_en && stat_hit) begin
      rd_data <= {access_error_flag, overflow_flag, 6'h00};
    end else if (rd_en && reg_hit) begin
      rd_data <= all_data[{addr, 3'h0} +: 8];
    end else begin
      rd_data <= 8'h00;
    end
  end
endmodule

//--- tb/mdu_checker.sv
// port checker for the multiply/divide unit
// assumes only the unit's top ports; bound below
`timescale 1ns/1ps
`include "mdu_defines.vh"
module mdu_checker (
  input wire core_clk,
  input wire resetn,
  input wire wr_en,
  input wire rd_en,
  input wire [`MDU_ADDR_W-1:0] addr,
  input wire [7:0] wr_data,
  input wire [7:0] rd_data,
  input wire busy,
  input wire access_error_flag,
  input wire overflow_flag
);
  reg [4:0] cnt;
  reg busy_d1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ----------------
  // busy run length
  // ----------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 5'h00;
      busy_d1 <= 1'b0;
    end else begin
      cnt <= busy ? cnt + 5'h01 : 5'h00;
      busy_d1 <= busy;
    end
  end
  property p_busy_len;
    $fell(busy) |-> (cnt == 5'h11 || cnt == 5'h09 || cnt == 5'h0B);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_busy_max;
    busy |-> cnt < 5'h11;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  property p_launch;
    $rose(busy) |-> $past(wr_en && addr == 3'h5);
  endproperty
  a_launch: assert property (p_launch) else $error("busy without final write");
  property p_err_set;
    busy && (wr_en || rd_en) && addr < 3'h6 |=> access_error_flag;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error flag not set");
  property p_err_hold;
    access_error_flag && !(rd_en && addr == 3'h6 && !busy) |=> access_error_flag;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag lost");
  property p_err_clear;
    access_error_flag && rd_en && addr == 3'h6 && !busy |=> !access_error_flag;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error flag not cleared");
  // overflow may only move as a run ends
  property p_ov_upd;
    $changed(overflow_flag) |-> !busy && (busy_d1 || $past(busy_d1));
  endproperty
  a_ov_upd: assert property (p_ov_upd) else $error("overflow moved mid run");
  property p_rd_status;
    rd_en && addr == 3'h6 |=> rd_data == {$past(access_error_flag), $past(overflow_flag), 6'h00};
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("status byte wrong");
  c_ldiv: cover property ($fell(busy) && cnt == 5'h11);
  c_sdiv: cover property ($fell(busy) && cnt == 5'h09);
  c_mul: cover property ($fell(busy) && cnt == 5'h0B);
endmodule
bind multiply_divide_unit mdu_checker chk (.core_clk(core_clk), .resetn(resetn), .wr_en(wr_en),
  .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .busy(busy),
  .access_error_flag(access_error_flag), .overflow_flag(overflow_flag));

//--- tb/multiply_divide_unit_test.sv
// self-checking bench for the multiply/divide unit
// assumes the unit and its checker compiled first
`timescale 1ns/1ps
module multiply_divide_unit_test;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] got;
  wire [7:0] rd_data;
  wire busy;
  wire access_error_flag;
  wire overflow_flag;
  int fail_count = 0;
  int checked = 0;
  int n;
  multiply_divide_unit dut (.core_clk(core_clk), .resetn(resetn), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .busy(busy),
    .access_error_flag(access_error_flag), .overflow_flag(overflow_flag));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  // ----------------
  // shared tasks
  // ----------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    wr_en = 1'b1;
    addr = a;
    wr_data = d;
    @(negedge core_clk);
    wr_en = 1'b0;
    @(negedge core_clk);
  endtask
  // data is only valid the cycle after the strobe
  task rd(input logic [2:0] a);
    rd_en = 1'b1;
    addr = a;
    @(negedge core_clk);
    got = rd_data;
    rd_en = 1'b0;
    @(negedge core_clk);
  endtask
  // order as hex digits; status reads interleaved
  task run(input logic [23:0] seq, input int len, input logic [47:0] v, input int exp_n,
    input logic ov, input logic poke, input logic [23:0] rseq, input int rlen, input logic [47:0] res);
    logic [2:0] a;
    for (int i = 0; i < len; i++) begin
      a = seq[4*(len-1-i)+:3];
      wr(a, v[8*a+:8]);
      if (i < len - 1) rd(3'h6);
    end
    // busy cycles already passed inside the last write (and the poke)
    n = poke ? 3 : 1;
    if (poke) wr(3'h2, 8'h5A);
    while (busy === 1'b1 && n < 40) begin
      n++;
      @(negedge core_clk);
    end
    check(n, exp_n);
    rd(3'h6);
    check(got, {poke, ov, 6'h00});
    rd(3'h6);
    check(got, {1'b0, ov, 6'h00});
    for (int i = 0; i < rlen; i++) begin
      a = rseq[4*(rlen-1-i)+:3];
      rd(a);
      check(got, res[8*a+:8]);
    end
    $display("run %h done", seq);
  endtask
  task bad(input logic [23:0] seq, input int len);
    for (int i = 0; i < len; i++) begin
      wr(seq[4*(len-1-i)+:3], 8'h01);
    end
    check(busy, 1'b0);
    $display("bad %h done", seq);
  endtask
  initial begin
    #(8 * 4000);
    fail_count++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    @(negedge core_clk);
    rd(3'h6);
    check(got, 8'h00);
    run(24'h012345, 6, {16'h0000, 32'h12345678}, 17, 1'b1, 1'b0, 24'h012345, 6, 48'h5678FFFFFFFF);
    run(24'h012345, 6, {16'h0010, 32'h12345678}, 17, 1'b0, 1'b1, 24'h012345, 6, 48'h000801234567);
    run(24'h0145, 4, {16'h0011, 16'h0000, 16'h1234}, 9, 1'b0, 1'b0, 24'h0145, 4, 48'h000200000112);
    run(24'h0145, 4, {16'h0000, 16'h0000, 16'h1234}, 9, 1'b1, 1'b0, 24'h0145, 4, 48'h12340000FFFF);
    run(24'h0415, 4, {16'h0002, 16'h0000, 16'hFFFF}, 11, 1'b1, 1'b0, 24'h0123, 4, 48'h00000001FFFE);
    bad(24'h045, 3);
    bad(24'h01245, 5);
    bad(24'h012, 3);
    run(24'h0415, 4, {16'h0100, 16'h0000, 16'h00FF}, 11, 1'b0, 1'b1, 24'h0123, 4, 48'h00000000FF00);
    test_done;
  end
endmodule
